// ### hdl/pwsrx_pkg.sv
// Functional notes
// - A rising edge on the line starts a word, and each bit runs from one rising edge to the next.
// - A bit is one when the line was high longer than low in its period, else zero.
// - Every field is sent and assembled least significant bit first.
// - A word is 11 bits: bits 0 to 2 are the address, bits 3 to 10 the data byte.
// - The data byte is committed on the rising edge of the stop bit after the eleventh bit.
// - A new word may start 4 us after the falling edge of the previous stop bit.
// - Low for the idle timeout of 200 us after the stop bit falling edge returns to idle.
// - High for the idle timeout starts pattern execution.
// - An interrupted word is discarded without writing any register.
`default_nettype none
package pwsrx_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int PHASE_MIN_NS = 500;
	localparam int PHASE_MAX_NS = 40_000;
	localparam int IDLE_TIMEOUT_NS = 200_000;
	localparam int NEXT_WORD_NS = 4_000;
	localparam int PHASE_MAX_CYC = PHASE_MAX_NS / CLK_NS;
	localparam int IDLE_TIMEOUT_CYC = (IDLE_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int NEXT_WORD_CYC = NEXT_WORD_NS / CLK_NS;
	localparam int CNT_W = 12;
	localparam int WORD_BITS = 11;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int ADDR_LSB = 0;
	localparam int DATA_LSB = 3;
	localparam int NUM_REGS = 5;
	localparam logic [7:0] REG0_RST = 8'h55;
	localparam logic [7:0] REG1_RST = 8'h55;
	localparam logic [7:0] REG2_RST = 8'h55;
	localparam logic [7:0] REG3_RST = 8'h00;
	localparam logic [7:0] REG4_RST = 8'h00;
	typedef enum logic [1:0]
	{
		PWSRX_IDLE = 2'h0,
		PWSRX_BITS = 2'h1,
		PWSRX_STOP = 2'h3
	} pwsrx_state_t;
endpackage : pwsrx_pkg
`default_nettype wire

// ### hdl/pwsrx_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pwsrx_regs
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Write request
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Register contents
	output logic [39:0] regs_flat
);
	logic [7:0] reg_q [5];
	logic [7:0] reg_d [5];

	always_comb
	begin
		for (int i = 0; i < pwsrx_pkg::NUM_REGS; i++)
		begin
			reg_d[i] = reg_q[i];
		end
		if (wr_en && wr_addr < 3'(pwsrx_pkg::NUM_REGS))
		begin
			reg_d[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_q[0] <= pwsrx_pkg::REG0_RST;
			reg_q[1] <= pwsrx_pkg::REG1_RST;
			reg_q[2] <= pwsrx_pkg::REG2_RST;
			reg_q[3] <= pwsrx_pkg::REG3_RST;
			reg_q[4] <= pwsrx_pkg::REG4_RST;
		end
		else
		begin
			for (int i = 0; i < pwsrx_pkg::NUM_REGS; i++)
			begin
				reg_q[i] <= reg_d[i];
			end
		end
	end

	assign regs_flat = {reg_q[4], reg_q[3], reg_q[2], reg_q[1], reg_q[0]};
endmodule : pwsrx_regs
`default_nettype wire

// ### hdl/pwsrx_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwsrx_top
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control line pin
	input wire logic ctrl_in,
	// Register contents
	output logic [39:0] regs_q,
	// Status
	output logic play_q,
	output logic idle_q,
	output logic wr_pulse_q
);
	logic sync1_q, sync2_q, prev_q;
	logic rise, fall;
	pwsrx_pkg::pwsrx_state_t st_q, st_d;
	logic [11:0] hi_q, hi_d, lo_q, lo_d;
	logic [17:0] tmo_q, tmo_d;
	logic [3:0] nbit_q, nbit_d;
	logic [10:0] sh_q, sh_d;
	logic play_d, idle_d, wr_d;
	logic wr_en;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;
	logic [39:0] regs_w;
	logic too_long;
	logic tmo_hit;

	// --------------------------------------------------------------------
	// Pin synchroniser
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= ctrl_in;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Only the second stage feeds logic; prev_q forms the edge detector.
	assign rise = sync2_q && !prev_q;
	assign fall = !sync2_q && prev_q;
	assign too_long = (hi_q > 12'(pwsrx_pkg::PHASE_MAX_CYC))
		|| (lo_q > 12'(pwsrx_pkg::PHASE_MAX_CYC));
	assign tmo_hit = (tmo_q >= 18'(pwsrx_pkg::IDLE_TIMEOUT_CYC))
		&& !rise && !fall;

	// Counts up to all ones and stays there, so a long level never wraps.
	function automatic logic [11:0] sat_inc(input logic [11:0] v);
		return (v == 12'hFFF) ? v : v + 12'h001;
	endfunction : sat_inc

	// --------------------------------------------------------------------
	// Level timeout and mode
	// --------------------------------------------------------------------
	// The timeout restarts at every edge, so a level held for the whole
	// interval decides between idle and pattern execution.
	always_comb
	begin
		tmo_d = tmo_q;
		play_d = play_q;
		idle_d = idle_q;
		if (rise || fall)
		begin
			tmo_d = '0;
		end
		else if (tmo_q != 18'h3FFFF)
		begin
			tmo_d = tmo_q + 18'h00001;
		end
		if (tmo_hit && sync2_q)
		begin
			play_d = 1'b1;
			idle_d = 1'b0;
		end
		else if (tmo_hit)
		begin
			play_d = 1'b0;
			idle_d = 1'b1;
		end
		else if (st_q == pwsrx_pkg::PWSRX_IDLE && rise)
		begin
			// A new word leaves both modes.
			play_d = 1'b0;
			idle_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tmo_q <= '0;
			play_q <= 1'b0;
			idle_q <= 1'b1;
		end
		else
		begin
			tmo_q <= tmo_d;
			play_q <= play_d;
			idle_q <= idle_d;
		end
	end

	// --------------------------------------------------------------------
	// Receiver
	// --------------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		hi_d = hi_q;
		lo_d = lo_q;
		nbit_d = nbit_q;
		sh_d = sh_q;
		wr_d = 1'b0;
		wr_en = 1'b0;
		wr_addr = sh_q[pwsrx_pkg::ADDR_LSB +: pwsrx_pkg::ADDR_W];
		wr_data = sh_q[pwsrx_pkg::DATA_LSB +: pwsrx_pkg::DATA_W];
		if (sync2_q)
		begin
			hi_d = sat_inc(hi_q);
		end
		else
		begin
			lo_d = sat_inc(lo_q);
		end
		// A timeout in mid-word drops the partial word.
		if (tmo_hit)
		begin
			st_d = pwsrx_pkg::PWSRX_IDLE;
		end
		unique case (st_q)
			pwsrx_pkg::PWSRX_IDLE:
			begin
				if (rise)
				begin
					st_d = pwsrx_pkg::PWSRX_BITS;
					nbit_d = 4'h0;
					hi_d = 12'h000;
					lo_d = 12'h000;
				end
			end
			pwsrx_pkg::PWSRX_BITS:
			begin
				// A phase beyond the limit abandons the word.
				if (too_long)
				begin
					st_d = pwsrx_pkg::PWSRX_IDLE;
				end
				else if (rise)
				begin
					sh_d = {(hi_q > lo_q), sh_q[10:1]};
					hi_d = 12'h000;
					lo_d = 12'h000;
					nbit_d = nbit_q + 4'h1;
					if (nbit_q == 4'(pwsrx_pkg::WORD_BITS - 1))
					begin
						st_d = pwsrx_pkg::PWSRX_STOP;
					end
				end
			end
			pwsrx_pkg::PWSRX_STOP:
			begin
				// Stop bit rising edge is the one that closed bit 10.
				wr_en = 1'b1;
				wr_d = 1'b1;
				st_d = pwsrx_pkg::PWSRX_IDLE;
			end
			default:
			begin
				st_d = pwsrx_pkg::PWSRX_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= pwsrx_pkg::PWSRX_IDLE;
			hi_q <= '0;
			lo_q <= '0;
			nbit_q <= '0;
			sh_q <= '0;
			wr_pulse_q <= 1'b0;
			regs_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			nbit_q <= nbit_d;
			sh_q <= sh_d;
			wr_pulse_q <= wr_d;
			regs_q <= regs_w;
		end
	end

	// --------------------------------------------------------------------
	// Register file
	// --------------------------------------------------------------------
	pwsrx_regs u_regs
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.regs_flat(regs_w)
	);
endmodule : pwsrx_top
`default_nettype wire

// ### sim/pwsrx_host.sv
`timescale 1ns/1ps
`default_nettype none
module pwsrx_host
(
	// Clock
	input wire logic ref_clk,
	// Control line
	output logic ctrl_in
);
	initial ctrl_in = 1'b0;
	task automatic hold(input logic v, input int n);
		ctrl_in = v;
		repeat (n) @(negedge ref_clk);
	endtask : hold
	// Sends nb bits, then the stop bit only when the word is whole.
	task automatic send(input logic [10:0] w, input int nb);
		for (int i = 0; i < nb; i++)
		begin
			hold(1'b1, w[i] ? 15 : 5);
			hold(1'b0, w[i] ? 5 : 15);
		end
		if (nb == 11)
		begin
			hold(1'b1, 10);
			hold(1'b0, pwsrx_pkg::NEXT_WORD_CYC);
		end
	endtask : send
endmodule : pwsrx_host
`default_nettype wire

// ### sim/pwsrx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pwsrx_checker
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Line and outputs
	input wire logic ctrl_in,
	input wire logic [39:0] regs_q,
	input wire logic play_q,
	input wire logic idle_q,
	input wire logic wr_pulse_q
);
	logic line_q;
	logic [11:0] run_q;
	logic [11:0] run_d;
	always_comb
	begin
		run_d = (run_q == 12'hFFF) ? run_q : run_q + 12'h001;
		if (ctrl_in != line_q)
			run_d = 12'h000;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			line_q <= 1'b0;
			run_q <= 12'h000;
		end
		else
		begin
			line_q <= ctrl_in;
			run_q <= run_d;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence low_run; (!ctrl_in)[*6]; endsequence
	sequence high_run; ctrl_in[*6]; endsequence
	pulse_one_a: assert property (wr_pulse_q |=> !wr_pulse_q)
		else $error("pulse long");
	pulse_line_a: assert property (wr_pulse_q |-> $past(ctrl_in, 2)
		&& !idle_q && !play_q) else $error("pulse cause");
	regs_hold_a: assert property (!$past(rst) && !$past(rst, 2)
		&& !$past(wr_pulse_q) |-> $stable(regs_q))
		else $error("regs moved");
	mode_excl_a: assert property (!(play_q && idle_q))
		else $error("both modes");
	play_rise_a: assert property ($rose(play_q)
		|-> ctrl_in && run_q >= 12'h7C6) else $error("play early");
	idle_rise_a: assert property ($rose(idle_q)
		|-> !ctrl_in && run_q >= 12'h7C6) else $error("idle early");
	idle_hold_a: assert property (low_run ##0 idle_q |=> idle_q)
		else $error("idle lost");
	play_hold_a: assert property (high_run ##0 play_q |=> play_q)
		else $error("play lost");
endmodule : pwsrx_checker
bind pwsrx_top pwsrx_checker pwsrx_checker_i (.ref_clk, .rst, .ctrl_in,
	.regs_q, .play_q, .idle_q, .wr_pulse_q);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ctrl_in;
	logic [39:0] regs_q;
	logic play_q, idle_q, wr_pulse_q;
	logic [39:0] exp_q = {pwsrx_pkg::REG4_RST, pwsrx_pkg::REG3_RST,
		pwsrx_pkg::REG2_RST, pwsrx_pkg::REG1_RST, pwsrx_pkg::REG0_RST};
	int miscompares = 0;
	int checked = 0;
	int pulses = 0;
	logic [10:0] rows [6] = '{{8'hA5, 3'h0}, {8'h3C, 3'h1},
		{8'h23, 3'h2}, {8'h81, 3'h3}, {8'hFF, 3'h4}, {8'h12, 3'h5}};
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
		if (wr_pulse_q === 1'b1)
			pulses++;
	pwsrx_top pwsrx_top_i (.ref_clk, .rst, .ctrl_in, .regs_q, .play_q,
		.idle_q, .wr_pulse_q);
	pwsrx_host pwsrx_host_i (.ref_clk, .ctrl_in);
	task automatic cmp(input logic [39:0] seen, input logic [39:0] want);
		checked++;
		if (seen !== want)
		begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, seen, want);
		end
	endtask : cmp
	task automatic complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic word(input logic [10:0] w);
		pwsrx_host_i.send(w, 11);
		if (w[2:0] < 3'h5)
			exp_q[8 * w[2:0] +: 8] = w[10:3];
		cmp(regs_q, exp_q);
	endtask : word
	initial
	begin
		#2_000_000;
		miscompares++;
		complete_run();
	end
	initial
	begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		cmp(regs_q, exp_q);
		cmp(idle_q, 1'b1);
		foreach (rows[i])
		begin
			word(rows[i]);
			cmp(pulses, i + 1);
		end
		// Interrupted word: five bits, then low far beyond a phase limit.
		pwsrx_host_i.send(11'h7FF, 5);
		pwsrx_host_i.hold(1'b0, 500);
		cmp(pulses, 6);
		cmp(regs_q, exp_q);
		word({8'h5A, 3'h3});
		pwsrx_host_i.hold(1'b0, 2100);
		cmp(idle_q, 1'b1);
		pwsrx_host_i.hold(1'b1, 2100);
		cmp({play_q, idle_q}, 2'h2);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
